// ==== inc/plcs_map.vh ====
// constants for the port link control/status register block
// assumes a 32-bit apb slave, word-aligned offsets, one clock domain
//
// Overview of operation
// - power-save field: 00 off, 01 l0s, 10 l1, 11 both
// - receive side may always enter l0s
// - read completion boundary bit reads zero
// - link disable bit zero on upstream port
// - retrain bit zero upstream, starts retrain downstream
// - common clock bit writable, always reads zero
// - extended sync selects 4096 fts, 1024 ts1
// - clock pm clear keeps clkreq low; downstream hardwired
// - bandwidth interrupt enables read-only on upstream port
// - current speed field, resets to 0010b
// - negotiated width resets x4 upstream, x2 downstream
// - training error set on fail, cleared at l0
// - training flag set while training, resets one
// - slot clock flag resets one, loadable
// - data link active flag mirrors dl_active state
`ifndef PLCS_MAP_VH
`define PLCS_MAP_VH

// register byte offsets
`define PLCS_LINK_OFF      8'hD0
`define PLCS_IRQ_STAT_OFF  8'hE0
`define PLCS_IRQ_EN_OFF    8'hE4
`define PLCS_IRQ_CLR_OFF   8'hE8

// control field positions
`define PLCS_ASPM_LO       0
`define PLCS_RCB_BIT       3
`define PLCS_LDIS_BIT      4
`define PLCS_RETRAIN_BIT   5
`define PLCS_CCLK_BIT      6
`define PLCS_XSYNC_BIT     7
`define PLCS_CLKPM_BIT     8
`define PLCS_HAWD_BIT      9
`define PLCS_BWIE_BIT      10
`define PLCS_ABWIE_BIT     11

// status field positions
`define PLCS_SPEED_LO      16
`define PLCS_WIDTH_LO      20
`define PLCS_TERR_BIT      26
`define PLCS_TRAIN_BIT     27
`define PLCS_SCLK_BIT      28
`define PLCS_DLA_BIT       29
`define PLCS_BWS_BIT       30
`define PLCS_ABWS_BIT      31

// reset values
`define PLCS_SPEED_RST     4'h2
`define PLCS_WIDTH_UP_RST  6'h04
`define PLCS_WIDTH_DN_RST  6'h02

// ordered-set counts for exit from low power
`define PLCS_FTS_EXT       13'h1000
`define PLCS_TS1_EXT       13'h0400

`endif

// ==== hdl/plcs_port_link.v ====
// per-port link control and status registers behind an apb slave
// assumes link training logic drives the status inputs synchronously to clk_i
`timescale 1ns/1ns
`include "plcs_map.vh"

module plcs_port_link #(
    parameter UPSTREAM = 1'b0,
    parameter [12:0] FTS_NORMAL = 13'h0080,
    parameter [12:0] TS1_NORMAL = 13'h0010
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        arst_n_i,
    // apb slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    // link state inputs from training logic
    input  wire [3:0]  speed_i,
    input  wire [5:0]  width_i,
    input  wire        width_vld_i,
    input  wire        train_active_i,
    input  wire        train_fail_i,
    input  wire        train_l0_i,
    input  wire        dl_active_i,
    input  wire        bw_mgmt_evt_i,
    input  wire        bw_auto_evt_i,
    input  wire        slot_clk_ld_i,
    input  wire        slot_clk_val_i,
    // link controls to training / power logic
    output reg         l0s_en_o,
    output reg         l1_en_o,
    output reg         rx_l0s_en_o,
    output reg         link_dis_o,
    output reg         retrain_o,
    output reg         common_clk_o,
    output reg  [12:0] fts_cnt_o,
    output reg  [12:0] ts1_cnt_o,
    output reg         clkreq_gate_en_o,
    output reg         hw_width_dis_o,
    output reg         irq_o
);

////////////////////////////////////////////////////////////////////////
// reset synchroniser
// assertion is immediate, release is clean on the clock; every other
// register resets from rst_n_r, so no flop leaves reset a cycle early
reg rst_s1_r;
reg rst_n_r;
always @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        rst_s1_r <= 1'b0;
        rst_n_r  <= 1'b0;
    end
    else
    begin
        rst_s1_r <= 1'b1;
        rst_n_r  <= rst_s1_r;
    end
end

////////////////////////////////////////////////////////////////////////
// register state
// control word fields, written by software
reg [1:0]  aspm_r;
reg        ldis_r;
reg        cclk_r;
reg        xsync_r;
reg        clkpm_r;
reg        hawd_r;
reg        bwie_r;
reg        abwie_r;
reg [1:0]  ien_r;
// link status fields, written by training logic
reg [3:0]  speed_r;
reg [5:0]  width_r;
reg        terr_r;
reg        train_r;
reg        sclk_r;
reg        dla_r;
// sticky bandwidth events: bit0 management, bit1 autonomous
wire [1:0] stat_w;

////////////////////////////////////////////////////////////////////////
// apb decode
// one-cycle access strobe; a write lands on the edge that ends the access
wire       acc      = psel_i & penable_i;
wire       wr       = acc & pwrite_i;
wire       wr_lnk   = wr & (paddr_i == `PLCS_LINK_OFF);
wire       wr_clr   = wr & (paddr_i == `PLCS_IRQ_CLR_OFF);
wire       wr_ien   = wr & (paddr_i == `PLCS_IRQ_EN_OFF);
// setup cycle: the slave prepares its answer here
wire       setup    = psel_i & ~penable_i;
// events and clears in status bit order; rw1c on link word or clear register
wire [1:0] stat_evt = {bw_auto_evt_i, bw_mgmt_evt_i};
wire [1:0] stat_clr = ({2{wr_lnk}} & pwdata_i[`PLCS_BWS_BIT +: 2]) | ({2{wr_clr}} & pwdata_i[1:0]);
// either enable source unmasks a status bit
wire [1:0] stat_en  = {abwie_r, bwie_r} | ien_r;

////////////////////////////////////////////////////////////////////////
// control word
// hardwired bits are forced at the write, so reads and outputs always agree
always @(posedge clk_i or negedge rst_n_r)
begin
    if (!rst_n_r)
    begin
        aspm_r  <= 2'h0;
        ldis_r  <= 1'b0;
        cclk_r  <= 1'b0;
        xsync_r <= 1'b0;
        clkpm_r <= 1'b0;
        hawd_r  <= 1'b0;
        bwie_r  <= 1'b0;
        abwie_r <= 1'b0;
    end
    else if (wr_lnk)
    begin
        aspm_r  <= pwdata_i[`PLCS_ASPM_LO +: 2];
        ldis_r  <= ~UPSTREAM & pwdata_i[`PLCS_LDIS_BIT];
        cclk_r  <= pwdata_i[`PLCS_CCLK_BIT];
        xsync_r <= pwdata_i[`PLCS_XSYNC_BIT];
        clkpm_r <= UPSTREAM & pwdata_i[`PLCS_CLKPM_BIT];
        hawd_r  <= pwdata_i[`PLCS_HAWD_BIT];
        // upstream keeps both enables at their reset value
        if (!UPSTREAM)
        begin
            bwie_r  <= pwdata_i[`PLCS_BWIE_BIT];
            abwie_r <= pwdata_i[`PLCS_ABWIE_BIT];
        end
    end
end

////////////////////////////////////////////////////////////////////////
// interrupt enable register; the clear register keeps no state of its own
always @(posedge clk_i or negedge rst_n_r)
begin
    if (!rst_n_r)
    begin
        ien_r <= 2'h0;
    end
    else if (wr_ien)
    begin
        ien_r <= pwdata_i[1:0];
    end
end

////////////////////////////////////////////////////////////////////////
// negotiated speed and width, held between valid strobes
// the width default depends on the port role, fixed per instance
always @(posedge clk_i or negedge rst_n_r)
begin
    if (!rst_n_r)
    begin
        speed_r <= `PLCS_SPEED_RST;
        width_r <= UPSTREAM ? `PLCS_WIDTH_UP_RST : `PLCS_WIDTH_DN_RST;
    end
    else if (width_vld_i)
    begin
        speed_r <= speed_i;
        width_r <= width_i;
    end
end

////////////////////////////////////////////////////////////////////////
// training flags
always @(posedge clk_i or negedge rst_n_r)
begin
    if (!rst_n_r)
    begin
        terr_r  <= 1'b0;
        train_r <= 1'b1;
    end
    else
    begin
        // a failure beside l0 entry wins, so an error is never lost
        if (train_fail_i)
        begin
            terr_r <= 1'b1;
        end
        else if (train_l0_i)
        begin
            terr_r <= 1'b0;
        end
        train_r <= train_active_i;
    end
end

////////////////////////////////////////////////////////////////////////
// slot clock and data link state
// slot clock changes only by a default load, never by a bus write
always @(posedge clk_i or negedge rst_n_r)
begin
    if (!rst_n_r)
    begin
        sclk_r <= 1'b1;
        dla_r  <= 1'b0;
    end
    else
    begin
        if (slot_clk_ld_i)
        begin
            sclk_r <= slot_clk_val_i;
        end
        dla_r <= dl_active_i;
    end
end

////////////////////////////////////////////////////////////////////////
// sticky bandwidth status, one flag per event
genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_stat
        reg flag_r;
        // set beats a clear in the same cycle, so no event is dropped
        always @(posedge clk_i or negedge rst_n_r)
        begin
            if (!rst_n_r)
            begin
                flag_r <= 1'b0;
            end
            else
            begin
                flag_r <= stat_evt[gi] | (flag_r & ~stat_clr[gi]);
            end
        end
        assign stat_w[gi] = flag_r;
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// link word as read: hidden and reserved control bits tie low
wire [31:0] link_word;
assign link_word[`PLCS_ASPM_LO +: 2]  = aspm_r;
assign link_word[2]                   = 1'b0;
assign link_word[`PLCS_RCB_BIT]       = 1'b0;
assign link_word[`PLCS_LDIS_BIT]      = ldis_r;
// retrain reads zero: the request is a pulse, never stored
assign link_word[`PLCS_RETRAIN_BIT]   = 1'b0;
// common clock is kept for its output but hidden from reads
assign link_word[`PLCS_CCLK_BIT]      = 1'b0;
assign link_word[`PLCS_XSYNC_BIT]     = xsync_r;
assign link_word[`PLCS_CLKPM_BIT]     = clkpm_r;
assign link_word[`PLCS_HAWD_BIT]      = hawd_r;
assign link_word[`PLCS_BWIE_BIT]      = bwie_r;
assign link_word[`PLCS_ABWIE_BIT]     = abwie_r;
assign link_word[15:12]               = 4'h0;
assign link_word[`PLCS_SPEED_LO +: 4] = speed_r;
assign link_word[`PLCS_WIDTH_LO +: 6] = width_r;
assign link_word[`PLCS_TERR_BIT]      = terr_r;
assign link_word[`PLCS_TRAIN_BIT]     = train_r;
assign link_word[`PLCS_SCLK_BIT]      = sclk_r;
assign link_word[`PLCS_DLA_BIT]       = dla_r;
assign link_word[`PLCS_BWS_BIT +: 2]  = stat_w;

////////////////////////////////////////////////////////////////////////
// read mux; unmapped and write-only addresses read zero
reg [31:0] rd_nxt;
always @*
begin
    rd_nxt = 32'h0000_0000;
    case (paddr_i)
        `PLCS_LINK_OFF:
        begin
            rd_nxt = link_word;
        end
        `PLCS_IRQ_STAT_OFF:
        begin
            rd_nxt[1:0] = stat_w;
        end
        `PLCS_IRQ_EN_OFF:
        begin
            rd_nxt[1:0] = ien_r;
        end
        default:
        begin
            rd_nxt = 32'h0000_0000;
        end
    endcase
end

// addresses that answer without an error
wire map_hit = (paddr_i == `PLCS_LINK_OFF) | (paddr_i == `PLCS_IRQ_STAT_OFF) |
               (paddr_i == `PLCS_IRQ_EN_OFF) | (paddr_i == `PLCS_IRQ_CLR_OFF);

////////////////////////////////////////////////////////////////////////
// apb answer
always @(posedge clk_i or negedge rst_n_r)
begin
    if (!rst_n_r)
    begin
        prdata_o  <= 32'h0000_0000;
        pready_o  <= 1'b0;
        pslverr_o <= 1'b0;
    end
    else
    begin
        // ready pulses in the first access cycle: zero wait states
        pready_o  <= setup;
        pslverr_o <= setup & ~map_hit;
        // outside the answer cycle the data bus reads zero
        prdata_o  <= (setup & ~pwrite_i) ? rd_nxt : 32'h0000_0000;
    end
end

////////////////////////////////////////////////////////////////////////
// link controls to training and power logic
// registered so every control output comes straight from a flip-flop
always @(posedge clk_i or negedge rst_n_r)
begin
    if (!rst_n_r)
    begin
        l0s_en_o         <= 1'b0;
        l1_en_o          <= 1'b0;
        rx_l0s_en_o      <= 1'b0;
        link_dis_o       <= 1'b0;
        retrain_o        <= 1'b0;
        common_clk_o     <= 1'b0;
        fts_cnt_o        <= 13'h0000;
        ts1_cnt_o        <= 13'h0000;
        clkreq_gate_en_o <= 1'b0;
        hw_width_dis_o   <= 1'b0;
    end
    else
    begin
        l0s_en_o         <= aspm_r[0];
        l1_en_o          <= aspm_r[1];
        // receive l0s never depends on the power-save field
        rx_l0s_en_o      <= 1'b1;
        link_dis_o       <= ldis_r;
        // retrain is a one-cycle pulse, never stored
        retrain_o        <= ~UPSTREAM & wr_lnk & pwdata_i[`PLCS_RETRAIN_BIT];
        common_clk_o     <= cclk_r;
        fts_cnt_o        <= xsync_r ? `PLCS_FTS_EXT : FTS_NORMAL;
        ts1_cnt_o        <= xsync_r ? `PLCS_TS1_EXT : TS1_NORMAL;
        // low keeps clkreq asserted; downstream never gates
        clkreq_gate_en_o <= clkpm_r;
        hw_width_dis_o   <= hawd_r;
    end
end

////////////////////////////////////////////////////////////////////////
// level interrupt while an enabled status flag stands
always @(posedge clk_i or negedge rst_n_r)
begin
    if (!rst_n_r)
    begin
        irq_o <= 1'b0;
    end
    else
    begin
        irq_o <= |(stat_w & stat_en);
    end
end

endmodule // plcs_port_link

// ==== test/plcs_port_link_assertions.sv ====
// checker for the port link register block, bound to its ports
// assumes apb transfers at least three cycles apart
`timescale 1ns/1ns
`include "plcs_map.vh"
module plcs_port_link_assertions #(
    parameter UPSTREAM = 1'b0,
    parameter [12:0] FTS_NORMAL = 13'h0080,
    parameter [12:0] TS1_NORMAL = 13'h0010
) (
    input wire        clk_i, arst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o,
    input wire [7:0]  paddr_i,
    input wire [31:0] pwdata_i, prdata_o,
    input wire        l0s_en_o, l1_en_o, rx_l0s_en_o, link_dis_o, retrain_o, common_clk_o, clkreq_gate_en_o,
    input wire [12:0] fts_cnt_o, ts1_cnt_o
);
    wire       wr_ctl = psel_i && penable_i && pwrite_i && paddr_i == `PLCS_LINK_OFF;
    reg [31:0] wd_q;
    reg [1:0]  up_q;
    // last control word; cycles since release, the design resyncs reset
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            wd_q <= 32'h0;
        else if (wr_ctl)
            wd_q <= pwdata_i;
    end
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            up_q <= 2'h0;
        else if (up_q != 2'h3)
            up_q <= up_q + 2'h1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    a_ctrl_follow: assert property (wr_ctl |=> ##1
        {l0s_en_o, l1_en_o, link_dis_o, common_clk_o} == {wd_q[0], wd_q[1], !UPSTREAM && wd_q[4], wd_q[6]})
        else $error("control outputs differ from written word");
    a_rx_l0s_on: assert property (up_q == 2'h3 |-> rx_l0s_en_o)
        else $error("receive l0s not allowed");
    a_retrain_start: assert property (wr_ctl && pwdata_i[5] && !UPSTREAM |-> ##[1:2] retrain_o)
        else $error("retrain not started");
    a_retrain_pulse: assert property (retrain_o |-> !UPSTREAM ##1 !retrain_o)
        else $error("retrain pulse wrong");
    a_sync_counts: assert property (wr_ctl |=> ##1 fts_cnt_o == (wd_q[7] ? `PLCS_FTS_EXT : FTS_NORMAL)
        && ts1_cnt_o == (wd_q[7] ? `PLCS_TS1_EXT : TS1_NORMAL)) else $error("ordered set counts wrong");
    a_clkreq_gate: assert property (wr_ctl |=> ##1 clkreq_gate_en_o == (UPSTREAM && wd_q[8]))
        else $error("clock request gating wrong");
    a_ctrl_zeros: assert property (pready_o && !pwrite_i && paddr_i == `PLCS_LINK_OFF
        |-> (prdata_o & 32'h0000F04C) == 32'h0) else $error("fixed zero control bits read set");
    a_ready_answer: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
        else $error("apb answer timing wrong");
    a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
        else $error("read data outside answer cycle");
endmodule // plcs_port_link_assertions
bind plcs_port_link plcs_port_link_assertions #(.UPSTREAM(UPSTREAM), .FTS_NORMAL(FTS_NORMAL),
    .TS1_NORMAL(TS1_NORMAL)) u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .l0s_en_o(l0s_en_o), .l1_en_o(l1_en_o),
    .rx_l0s_en_o(rx_l0s_en_o), .link_dis_o(link_dis_o), .retrain_o(retrain_o), .common_clk_o(common_clk_o),
    .clkreq_gate_en_o(clkreq_gate_en_o), .fts_cnt_o(fts_cnt_o), .ts1_cnt_o(ts1_cnt_o));

// ==== test/plcs_link_partner.sv ====
// behavioural training logic: trains after reset and on each retrain pulse
// assumes retrain_i is a one-cycle pulse in the clk_i domain
`timescale 1ns/1ns
module plcs_link_partner (
    input wire        clk_i, arst_n_i, retrain_i, fail_i,
    output wire [3:0] speed_o,
    output wire [5:0] width_o,
    output wire       vld_o, active_o, fail_o, l0_o, mgmt_o, auto_o,
    output reg        dla_o
);
    reg [5:0] cnt_r;
    wire      done = cnt_r == 6'h01;
    // count down one training run; retrain restarts a short one
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cnt_r <= 6'h20;
        else
            cnt_r <= retrain_i ? 6'h08 : (cnt_r != 6'h00 ? cnt_r - 6'h01 : cnt_r);
    end
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            dla_o <= 1'b0;
        else if (done)
            dla_o <= !fail_i;
    end
    assign active_o = cnt_r != 6'h00;
    assign vld_o    = done && !fail_i;
    assign l0_o     = vld_o;
    assign fail_o   = done && fail_i;
    assign mgmt_o   = vld_o;
    assign auto_o   = fail_o;
    // x1 at 2.5 Gb/s when valid, junk otherwise so stale values show
    assign speed_o  = vld_o ? 4'h1 : 4'hE;
    assign width_o  = vld_o ? 6'h01 : 6'h3E;
endmodule // plcs_link_partner

// ==== test/testbench.sv ====
// self-checking bench for a downstream port link register block
// assumes zero-wait apb answers and the training model beside it
`timescale 1ns/1ns
`include "plcs_map.vh"
module testbench;
    logic        clk_i = 1'b0, arst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, ld = 1'b0;
    logic        sval = 1'b1, fail = 1'b0, er, pready_o, pslverr_o, l0s, l1, rxl, ldis, rt, cc, ckr, hwd, irq_o;
    logic        vld, act, tf, l0, dla, mg, au;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [3:0]  spd;
    logic [5:0]  wid;
    logic [12:0] fts, ts1;
    int          mismatches = 0, num_checks = 0;
    logic [31:0] rw [6] = '{32'h0000FFDF, 32'h1, 32'h2, 32'h3, 32'h140, 32'h0};
    logic [15:0] rc [6] = '{16'h0E93, 16'h1, 16'h2, 16'h3, 16'h0, 16'h0};
    logic [5:0]  ro [6] = '{6'h3E, 6'h28, 6'h18, 6'h38, 6'h0A, 6'h08};
    always #5 clk_i = ~clk_i;
    plcs_port_link DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .speed_i(spd), .width_i(wid), .width_vld_i(vld), .train_active_i(act),
        .train_fail_i(tf), .train_l0_i(l0), .dl_active_i(dla), .bw_mgmt_evt_i(mg), .bw_auto_evt_i(au),
        .slot_clk_ld_i(ld), .slot_clk_val_i(sval), .l0s_en_o(l0s), .l1_en_o(l1), .rx_l0s_en_o(rxl),
        .link_dis_o(ldis), .retrain_o(rt), .common_clk_o(cc), .fts_cnt_o(fts), .ts1_cnt_o(ts1),
        .clkreq_gate_en_o(ckr), .hw_width_dis_o(hwd), .irq_o(irq_o));
    plcs_link_partner u_partner (.clk_i(clk_i), .arst_n_i(arst_n_i), .retrain_i(rt), .fail_i(fail),
        .speed_o(spd), .width_o(wid), .vld_o(vld), .active_o(act), .fail_o(tf), .l0_o(l0), .mgmt_o(mg),
        .auto_o(au), .dla_o(dla));
    ////////////////////////////////////////////////////////////////////////
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 16);
        chk(32'(pready_o), 32'h1);
        if (pready_o !== 1'b1)
            complete_run;
        rd = prdata_o;
        er = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
    endtask
    // training is given up to 8 cycles to start, then status is polled until it ends
    task trained;
        int n;
        for (n = 0; n < 8 && act !== 1'b1; n++)
            @(posedge clk_i);
        for (n = 0; n < 20; n++)
        begin
            apb(1'b0, `PLCS_LINK_OFF, 32'h0);
            if (rd[27] === 1'b0)
                break;
        end
        chk(32'(rd[27]), 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        apb(1'b0, `PLCS_LINK_OFF, 32'h0);
        chk(rd, 32'h18220000);
        trained;
        chk(rd, 32'h70110000);
        $display("test reset and training done");
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, `PLCS_LINK_OFF, rw[i]);
            apb(1'b0, `PLCS_LINK_OFF, 32'h0);
            chk(32'(rd[15:0]), 32'(rc[i]));
            chk(32'({l0s, l1, rxl, ldis, cc, ckr}), 32'(ro[i]));
            chk(32'(hwd), 32'(rw[i][9]));
            chk(32'({fts, ts1}), rw[i][7] ? {6'h0, 13'h1000, 13'h0400} : {6'h0, 13'h0080, 13'h0010});
        end
        $display("test control table done");
        apb(1'b1, `PLCS_IRQ_EN_OFF, 32'h1);
        apb(1'b0, `PLCS_IRQ_STAT_OFF, 32'h0);
        chk({rd[30:0], irq_o}, 32'h3);
        apb(1'b1, `PLCS_IRQ_CLR_OFF, 32'h1);
        apb(1'b0, `PLCS_LINK_OFF, 32'h0);
        chk({rd[31:30], 29'h0, irq_o}, 32'h0);
        fail <= 1'b1;
        apb(1'b1, `PLCS_LINK_OFF, 32'h820);
        trained;
        chk(rd & 32'hEC000000, 32'h84000000);
        chk(32'(irq_o), 32'h1);
        apb(1'b1, `PLCS_LINK_OFF, 32'h80000800);
        apb(1'b0, `PLCS_LINK_OFF, 32'h0);
        chk({rd[31], 30'h0, irq_o}, 32'h0);
        fail <= 1'b0;
        apb(1'b1, `PLCS_LINK_OFF, 32'h20);
        trained;
        chk(rd & 32'h6C000000, 32'h60000000);
        $display("test retrain and interrupts done");
        @(posedge clk_i);
        {ld, sval} <= 2'b10;
        @(posedge clk_i);
        ld <= 1'b0;
        apb(1'b0, `PLCS_LINK_OFF, 32'h0);
        chk(32'(rd[28]), 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        $display("test slot clock and unmapped done");
        arst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(32'({l0s, l1, rxl, ldis, cc, ckr, irq_o}), 32'h0);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        apb(1'b0, `PLCS_LINK_OFF, 32'h0);
        chk(rd, 32'h18220000);
        $display("test mid-run reset done");
        complete_run;
    end
endmodule // testbench
